// *** shared/tpr_pkg.sv ***
// constants, types and register map of the touch panel readout block
package tpr_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG    = 8'h07;  // converter_config
  localparam logic [7:0] ADDR_MODE   = 8'h08;  // touch_mode_select
  localparam logic [7:0] ADDR_RES_LO = 8'h09;  // conversion_result_low
  localparam logic [7:0] ADDR_RES_HI = 8'h0a;  // conversion_result_high

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_POWER_BIT = 7;  // converter power-on
  localparam int CFG_START_BIT = 6;  // conversion start
  localparam int CFG_DONE_BIT  = 5;  // conversion_done_flag
  localparam int CFG_VREF_BIT  = 4;  // reference enable
  localparam int CFG_CH_MSB    = 3;  // channel field top bit
  localparam int MODE_MSB      = 2;  // mode field top bit
  localparam int RES_W         = 10; // result width
  localparam int RES_LO_MSB    = 7;  // top result bit in low register
  localparam int RES_HI_LSB    = 8;  // first result bit in high register

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0]       MODE_RST  = 3'h7;   // touch disabled
  localparam logic             POWER_RST = 1'b0;
  localparam logic             START_RST = 1'b0;
  localparam logic             DONE_RST  = 1'b1;
  localparam logic             VREF_RST  = 1'b0;
  localparam logic [3:0]       CH_RST    = 4'h0;
  localparam logic [RES_W-1:0] RES_RST   = 10'h000;

  // ------------------------------------------------------------
  // mode codes and touch channels
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_XPOS    = 3'h0;
  localparam logic [2:0] MODE_YPOS    = 3'h1;
  localparam logic [2:0] MODE_PRESS   = 3'h2;
  localparam logic [2:0] MODE_PLATE_X = 3'h3;
  localparam logic [2:0] MODE_PLATE_Y = 3'h4;
  localparam logic [2:0] MODE_STBY    = 3'h5;
  localparam logic [2:0] MODE_ADC     = 3'h6;
  localparam logic [2:0] MODE_OFF     = 3'h7;
  localparam logic [3:0] CH_TOUCH_ALL = 4'he;  // touch_converter_channel
  localparam logic [3:0] CH_TOUCH_XY  = 4'hf;  // position modes only

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {DRV_OPEN, DRV_REF, DRV_GND, DRV_STBY, DRV_ADC} tpr_drv_t;
  typedef enum logic {CONV_IDLE, CONV_BUSY} tpr_conv_state_t;

  // analog switch enables of one panel pin; all low leaves the pin open
  typedef struct packed {
    logic to_ref;   // panel_reference_drive
    logic to_gnd;   // ground
    logic to_stby;  // standby_drive_level
    logic to_adc;   // routed to converter input
  } tpr_pin_ctl_t;

  // converter_config contents
  typedef struct packed {
    logic       power;
    logic       start;
    logic       done;
    logic       vref;
    logic [3:0] chan;
  } tpr_cfg_t;

  // register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpr_reg_req_t;

endpackage : tpr_pkg

// *** src/tpr_pin_drive.sv ***
// registered switch enables for one resistive panel pin
`timescale 1ns/1ps
module tpr_pin_drive (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            reset,
  // requested drive
  input  wire tpr_pkg::tpr_drv_t drive,
  // switch enables
  output tpr_pkg::tpr_pin_ctl_t  ctl
);

  // ------------------------------------------------------------
  // drive decode
  // ------------------------------------------------------------
  tpr_pkg::tpr_pin_ctl_t ctl_r;    // registered enables
  tpr_pkg::tpr_pin_ctl_t ctl_nxt;  // next enables

  // one switch at most is closed per pin
  always_comb begin
    ctl_nxt = '0;
    case (drive)
      tpr_pkg::DRV_REF:  ctl_nxt.to_ref  = 1'b1;
      tpr_pkg::DRV_GND:  ctl_nxt.to_gnd  = 1'b1;
      tpr_pkg::DRV_STBY: ctl_nxt.to_stby = 1'b1;
      tpr_pkg::DRV_ADC:  ctl_nxt.to_adc  = 1'b1;
      default:           ctl_nxt         = '0;  // open
    endcase
  end

  // register so the switches never glitch on a mode change
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign ctl = ctl_r;

endmodule : tpr_pin_drive

// *** src/tpr_touch_readout.sv ***
// touch panel mode control, converter sequencing and result registers
//
// Operation
// R1 - three-bit mode field, upper zero, resets ones
// R2 - modes 000/001 drive pair, sense other
// R3 - pressure mode and plate x/y drives
// R4 - standby: x pins standby level, y grounded
// R5 - converter mode routes all pins, none driven
// R6 - mode 111 opens pins, disables everything; vref_enable still follows the config bit
// R7 - host sets mode and matching channel
// R8 - host powers converter before touch measurement
// R9 - host selects channel 1110 for touch
// R10 - host starts, polls done flag
// R11 - host reads both result registers
// R12 - ten-bit result split low/high, rest zero
// R13 - start bit clears itself on completion
// R14 - done flag read-only, resets to one
// R15 - channel 1111 routes only position modes
// R16 - power bit gates converter, resets zero
// R17 - writes to read-only bits ignored
// R18 - result holds until next completion
`timescale 1ns/1ps
module tpr_touch_readout (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset,
  // register access
  input  wire tpr_pkg::tpr_reg_req_t    reg_req,
  output logic [7:0]                    reg_rdata,
  // converter macro, same clock
  output logic                          conv_start,
  input  wire logic                     conv_done_in,
  input  wire logic [9:0]               conv_result,
  output logic                          converter_enable,
  output logic                          vref_enable,
  output logic [3:0]                    converter_channel,
  output logic                          touch_to_converter,
  // panel pin switches
  output tpr_pkg::tpr_pin_ctl_t         panel_x_plus,
  output tpr_pkg::tpr_pin_ctl_t         panel_x_minus,
  output tpr_pkg::tpr_pin_ctl_t         panel_y_plus,
  output tpr_pkg::tpr_pin_ctl_t         panel_y_minus,
  // touch controller control
  output logic                          touch_controller_enable,
  output logic                          touch_irq_enable
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [2:0]                 mode_r, mode_nxt;      // touch_mode_select field
  tpr_pkg::tpr_cfg_t          cfg_r, cfg_nxt;        // converter_config
  logic [9:0]                 result_r, result_nxt;  // last completed result
  tpr_pkg::tpr_conv_state_t   state_r, state_nxt;    // conversion sequencer
  logic [7:0]                 rdata_r, rdata_nxt;    // read data register
  logic                       pulse_r, pulse_nxt;    // conversion start pulse
  logic                       conv_en_r, conv_en_nxt;
  logic                       tch_en_r, tch_en_nxt;
  logic                       route_r, route_nxt;
  logic                       wr_mode, wr_cfg;       // write decodes
  logic                       start_ok;              // start request accepted
  tpr_pkg::tpr_drv_t          drv_xp, drv_xm, drv_yp, drv_ym;

  // ------------------------------------------------------------
  // register writes and conversion sequencing
  // ------------------------------------------------------------
  always_comb begin
    mode_nxt   = mode_r;
    cfg_nxt    = cfg_r;
    result_nxt = result_r;
    state_nxt  = state_r;
    pulse_nxt  = 1'b0;
    wr_mode    = reg_req.wr && (reg_req.addr == tpr_pkg::ADDR_MODE);
    wr_cfg     = reg_req.wr && (reg_req.addr == tpr_pkg::ADDR_CFG);
    // only the mode field is writable; result offsets take no writes
    if (wr_mode) begin
      mode_nxt = reg_req.wdata[tpr_pkg::MODE_MSB:0];  // [R1] [R17]
    end
    // done is never written by software
    if (wr_cfg) begin
      cfg_nxt.power = reg_req.wdata[tpr_pkg::CFG_POWER_BIT];  // [R16]
      cfg_nxt.vref  = reg_req.wdata[tpr_pkg::CFG_VREF_BIT];
      cfg_nxt.chan  = reg_req.wdata[tpr_pkg::CFG_CH_MSB:0];
    end
    // start needs the converter powered and touch logic not disabled
    start_ok = wr_cfg && reg_req.wdata[tpr_pkg::CFG_START_BIT]
               && reg_req.wdata[tpr_pkg::CFG_POWER_BIT]
               && (mode_r != tpr_pkg::MODE_OFF);  // [R6] [R16]
    case (state_r)
      tpr_pkg::CONV_IDLE: begin
        if (start_ok) begin
          cfg_nxt.start = 1'b1;
          cfg_nxt.done  = 1'b0;  // [R14]
          pulse_nxt     = 1'b1;
          state_nxt     = tpr_pkg::CONV_BUSY;
        end
      end
      tpr_pkg::CONV_BUSY: begin
        if (conv_done_in) begin
          // completion wins over a same-cycle power-down
          result_nxt    = conv_result;  // [R18]
          cfg_nxt.start = 1'b0;         // [R13]
          cfg_nxt.done  = 1'b1;         // [R14]
          state_nxt     = tpr_pkg::CONV_IDLE;
        end else if (!cfg_nxt.power || (mode_r == tpr_pkg::MODE_OFF)) begin
          // abort: no result, done stays low
          cfg_nxt.start = 1'b0;  // [R6] [R16]
          state_nxt     = tpr_pkg::CONV_IDLE;
        end
      end
      default: state_nxt = tpr_pkg::CONV_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_req.rd) begin
      if (reg_req.addr == tpr_pkg::ADDR_CFG) begin
        rdata_nxt = cfg_r;  // [R13] [R14]
      end else if (reg_req.addr == tpr_pkg::ADDR_MODE) begin
        rdata_nxt = {5'h00, mode_r};  // [R1]
      end else if (reg_req.addr == tpr_pkg::ADDR_RES_LO) begin
        rdata_nxt = result_r[tpr_pkg::RES_LO_MSB:0];  // [R12]
      end else if (reg_req.addr == tpr_pkg::ADDR_RES_HI) begin
        rdata_nxt = {6'h00, result_r[tpr_pkg::RES_W-1:tpr_pkg::RES_HI_LSB]};  // [R12]
      end else begin
        rdata_nxt = 8'h00;  // unmapped
      end
    end
  end

  // ------------------------------------------------------------
  // derived controls
  // ------------------------------------------------------------
  always_comb begin
    conv_en_nxt = cfg_r.power && (mode_r != tpr_pkg::MODE_OFF);  // [R6] [R16]
    tch_en_nxt  = (mode_r != tpr_pkg::MODE_OFF);                 // [R6]
    // 1111 only serves the two position modes
    route_nxt   = tch_en_nxt && ((cfg_r.chan == tpr_pkg::CH_TOUCH_ALL)
                  || ((cfg_r.chan == tpr_pkg::CH_TOUCH_XY)
                      && ((mode_r == tpr_pkg::MODE_XPOS)
                          || (mode_r == tpr_pkg::MODE_YPOS))));  // [R15]
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_r    <= tpr_pkg::MODE_RST;
      cfg_r     <= {tpr_pkg::POWER_RST, tpr_pkg::START_RST, tpr_pkg::DONE_RST,
                    tpr_pkg::VREF_RST, tpr_pkg::CH_RST};
      result_r  <= tpr_pkg::RES_RST;
      state_r   <= tpr_pkg::CONV_IDLE;
      rdata_r   <= 8'h00;
      pulse_r   <= 1'b0;
      conv_en_r <= 1'b0;
      tch_en_r  <= 1'b0;
      route_r   <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      cfg_r     <= cfg_nxt;
      result_r  <= result_nxt;
      state_r   <= state_nxt;
      rdata_r   <= rdata_nxt;
      pulse_r   <= pulse_nxt;
      conv_en_r <= conv_en_nxt;
      tch_en_r  <= tch_en_nxt;
      route_r   <= route_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin drive per mode
  // ------------------------------------------------------------
  always_comb begin
    drv_xp = tpr_pkg::DRV_OPEN;
    drv_xm = tpr_pkg::DRV_OPEN;
    drv_yp = tpr_pkg::DRV_OPEN;
    drv_ym = tpr_pkg::DRV_OPEN;
    case (mode_r)
      tpr_pkg::MODE_XPOS: begin  // [R2]
        drv_xp = tpr_pkg::DRV_REF;
        drv_xm = tpr_pkg::DRV_GND;
        drv_yp = tpr_pkg::DRV_ADC;
      end
      tpr_pkg::MODE_YPOS: begin  // [R2]
        drv_xp = tpr_pkg::DRV_ADC;
        drv_yp = tpr_pkg::DRV_REF;
        drv_ym = tpr_pkg::DRV_GND;
      end
      tpr_pkg::MODE_PRESS: begin  // [R3]
        drv_xp = tpr_pkg::DRV_REF;
        drv_xm = tpr_pkg::DRV_REF;
        drv_yp = tpr_pkg::DRV_GND;
        drv_ym = tpr_pkg::DRV_GND;
      end
      tpr_pkg::MODE_PLATE_X: begin  // [R3]
        drv_xp = tpr_pkg::DRV_REF;
        drv_xm = tpr_pkg::DRV_GND;
      end
      tpr_pkg::MODE_PLATE_Y: begin  // [R3]
        drv_yp = tpr_pkg::DRV_REF;
        drv_ym = tpr_pkg::DRV_GND;
      end
      tpr_pkg::MODE_STBY: begin  // [R4]
        drv_xp = tpr_pkg::DRV_STBY;
        drv_xm = tpr_pkg::DRV_STBY;
        drv_yp = tpr_pkg::DRV_GND;
        drv_ym = tpr_pkg::DRV_GND;
      end
      tpr_pkg::MODE_ADC: begin  // [R5]
        drv_xp = tpr_pkg::DRV_ADC;
        drv_xm = tpr_pkg::DRV_ADC;
        drv_yp = tpr_pkg::DRV_ADC;
        drv_ym = tpr_pkg::DRV_ADC;
      end
      default: begin  // all open [R6]
        drv_xp = tpr_pkg::DRV_OPEN;
      end
    endcase
  end

  tpr_pin_drive u_xp (.clock(clock), .reset(reset), .drive(drv_xp), .ctl(panel_x_plus));
  tpr_pin_drive u_xm (.clock(clock), .reset(reset), .drive(drv_xm), .ctl(panel_x_minus));
  tpr_pin_drive u_yp (.clock(clock), .reset(reset), .drive(drv_yp), .ctl(panel_y_plus));
  tpr_pin_drive u_ym (.clock(clock), .reset(reset), .drive(drv_ym), .ctl(panel_y_minus));

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata               = rdata_r;
  assign conv_start              = pulse_r;
  assign converter_enable        = conv_en_r;
  assign vref_enable             = cfg_r.vref;
  assign converter_channel       = cfg_r.chan;
  assign touch_to_converter      = route_r;
  assign touch_controller_enable = tch_en_r;
  assign touch_irq_enable        = tch_en_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_start_req;
    (state_r == tpr_pkg::CONV_IDLE) && start_ok;
  endsequence
  sequence s_busy_seen;
    conv_start && cfg_r.start && !cfg_r.done;
  endsequence

  mode_read_zero_a: assert property (reg_req.rd && reg_req.addr == tpr_pkg::ADDR_MODE |=> // [R1]
    reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(mode_r)) else $error("mode read bad");
  xpos_pins_a: assert property (mode_r == tpr_pkg::MODE_XPOS |=> panel_x_plus.to_ref // [R2]
    && panel_x_minus.to_gnd && panel_y_plus.to_adc && panel_y_minus == '0)
    else $error("x position drive bad");
  press_pins_a: assert property (mode_r == tpr_pkg::MODE_PRESS |=> panel_x_minus.to_ref // [R3]
    && panel_y_plus.to_gnd && panel_y_minus.to_gnd) else $error("pressure drive bad");
  stby_pins_a: assert property (mode_r == tpr_pkg::MODE_STBY |=> panel_x_plus.to_stby // [R4]
    && panel_x_minus.to_stby && panel_y_minus.to_gnd) else $error("standby drive bad");
  adc_pins_a: assert property (mode_r == tpr_pkg::MODE_ADC |=> panel_x_minus.to_adc // [R5]
    && !panel_x_minus.to_ref && panel_y_minus.to_adc) else $error("converter mode bad");
  off_state_a: assert property (mode_r == tpr_pkg::MODE_OFF |=> !converter_enable // [R6]
    && !touch_irq_enable && panel_x_plus == '0) else $error("disabled mode bad");
  start_seq_a: assert property (s_start_req |=> s_busy_seen ##1 !conv_start) // [R13]
    else $error("start sequence bad");
  done_clear_a: assert property (state_r == tpr_pkg::CONV_BUSY && conv_done_in |=> // [R14]
    !cfg_r.start && cfg_r.done && result_r == $past(conv_result)) else $error("done bad");
  result_hold_a: assert property (!(state_r == tpr_pkg::CONV_BUSY && conv_done_in) |=> // [R18]
    $stable(result_r)) else $error("result changed");
  result_hi_a: assert property (reg_req.rd && reg_req.addr == tpr_pkg::ADDR_RES_HI |=> // [R12]
    reg_rdata == {6'h00, $past(result_r[9:8])}) else $error("high result bad");
  power_gate_a: assert property (!cfg_r.power |=> !converter_enable) // [R16]
    else $error("converter on without power");
  xy_route_a: assert property (cfg_r.chan == tpr_pkg::CH_TOUCH_XY // [R15]
    && mode_r == tpr_pkg::MODE_PRESS |=> !touch_to_converter) else $error("route bad");

endmodule : tpr_touch_readout

// *** dv/tpr_conv_model.sv ***
// behavioural converter macro that answers the touch readout block
`timescale 1ns/1ps
module tpr_conv_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // control from the readout block
  input  wire logic       conv_start,
  input  wire logic       converter_enable,
  // analog level and conversion time chosen by the bench
  input  wire logic [9:0] sample,
  input  wire logic [7:0] delay,
  // answer towards the readout block
  output logic            conv_done_in,
  output logic [9:0]      conv_result
);
  logic       run_r;  // conversion under way
  logic [7:0] cnt_r;  // cycles still to wait

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // an unpowered converter ignores start; data toggles whenever not valid
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      run_r        <= 1'b0;
      cnt_r        <= 8'h00;
      conv_done_in <= 1'b0;
      conv_result  <= 10'h000;
    end else begin
      conv_done_in <= 1'b0;
      conv_result  <= ~conv_result;
      if (run_r && cnt_r == 8'h00) begin
        conv_done_in <= 1'b1;
        conv_result  <= sample;
        run_r        <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (conv_start && converter_enable) begin
        run_r <= 1'b1;
        cnt_r <= delay;
      end
    end
  end
endmodule : tpr_conv_model

// *** dv/test_tpr_touch_readout.sv ***
// self-checking bench of the touch panel readout block
`timescale 1ns/1ps
module test_tpr_touch_readout;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] exp; logic [7:0] mask;} tpr_note_t;
  logic                  clock, reset;           // clock and reset
  tpr_pkg::tpr_reg_req_t reg_req;                // register request
  logic [7:0]            reg_rdata, last_rd;     // read data
  logic                  conv_start, conv_done_in, converter_enable;
  logic                  vref_enable, touch_to_converter;
  logic [9:0]            conv_result, sample;    // converter data
  logic [7:0]            delay;                  // model conversion time
  logic [3:0]            converter_channel;
  tpr_pkg::tpr_pin_ctl_t panel_x_plus, panel_x_minus, panel_y_plus, panel_y_minus;
  logic                  touch_controller_enable, touch_irq_enable;
  tpr_note_t             notes[$];               // expected read results
  tpr_note_t             cur;                    // note being compared
  logic [1:0]            rd_pipe;                // read strobe history
  logic [9:0]            res_prev;               // last completed result
  int                    failures, num_checks, cycles, seed;

  // ----------------------------------------------------------------
  // design and converter model
  // ----------------------------------------------------------------
  tpr_touch_readout i_tpr_touch_readout (.clock(clock), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_done_in(conv_done_in),
    .conv_result(conv_result), .converter_enable(converter_enable),
    .vref_enable(vref_enable), .converter_channel(converter_channel),
    .touch_to_converter(touch_to_converter), .panel_x_plus(panel_x_plus),
    .panel_x_minus(panel_x_minus), .panel_y_plus(panel_y_plus),
    .panel_y_minus(panel_y_minus), .touch_controller_enable(touch_controller_enable),
    .touch_irq_enable(touch_irq_enable));
  tpr_conv_model i_tpr_conv_model (.clock(clock), .reset(reset), .conv_start(conv_start),
    .converter_enable(converter_enable), .sample(sample), .delay(delay),
    .conv_done_in(conv_done_in), .conv_result(conv_result));

  // ----------------------------------------------------------------
  // clock, timeout and read monitor
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      give_verdict();
    end
  end
  // remembers which edges took a read
  always @(posedge clock or posedge reset) begin
    if (reset) rd_pipe <= 2'b00;
    else rd_pipe <= {rd_pipe[0], reg_req.rd};
  end
  // compares read data one and a half cycles after the read was answered
  always @(negedge clock) begin
    if (rd_pipe[1]) begin
      cur = notes.pop_front();
      if (cur.mask != 8'h00) check(reg_rdata & cur.mask, cur.exp);
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req = {1'b1, 1'b0, a, d};
    @(negedge clock);
    reg_req = '0;
  endtask : wr
  // one-cycle read strobe; mask zero means poll only
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clock);
    notes.push_back('{e, m});
    reg_req = {1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    reg_req = '0;
    @(negedge clock);
    last_rd = reg_rdata;
  endtask : rd
  // expected switch enables {x_plus, x_minus, y_plus, y_minus}, each {ref,gnd,stby,adc}
  function automatic logic [15:0] pins_exp(input logic [2:0] m);
    case (m)
      3'h0: pins_exp = 16'h8410;
      3'h1: pins_exp = 16'h1084;
      3'h2: pins_exp = 16'h8844;
      3'h3: pins_exp = 16'h8400;
      3'h4: pins_exp = 16'h0084;
      3'h5: pins_exp = 16'h2244;
      3'h6: pins_exp = 16'h1111;
      default: pins_exp = 16'h0000;
    endcase
  endfunction : pins_exp
  // full host sequence of one touch conversion
  task automatic convert(input logic [9:0] s, input logic [7:0] dl);
    @(negedge clock);
    sample = s;
    delay  = dl;
    wr(tpr_pkg::ADDR_CFG, 8'hce);
    if (dl > 8'h08) begin
      rd(tpr_pkg::ADDR_CFG, 8'hce, 8'hff);
      rd(tpr_pkg::ADDR_RES_LO, res_prev[7:0], 8'hff);
      wr(tpr_pkg::ADDR_RES_LO, 8'h55);
    end
    last_rd = 8'h00;
    for (int i = 0; i < 100; i++) begin
      if (last_rd[5] !== 1'b1) rd(tpr_pkg::ADDR_CFG, 8'h00, 8'h00);
    end
    check(last_rd[5], 1'b1);
    rd(tpr_pkg::ADDR_CFG, 8'hae, 8'hff);
    rd(tpr_pkg::ADDR_RES_LO, s[7:0], 8'hff);
    rd(tpr_pkg::ADDR_RES_HI, {6'h00, s[9:8]}, 8'hff);
    res_prev = s;
  endtask : convert
  // counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic       pw, vr;  // random power and reference bits
    logic [4:0] up;      // random read-only mode bits
    reset    = 1'b1;
    reg_req  = '0;
    sample   = 10'h000;
    delay    = 8'h00;
    seed     = 40;
    res_prev = 10'h000;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    // reset state and read-only places
    check({panel_x_plus, panel_x_minus, panel_y_plus, panel_y_minus}, 16'h0000);
    rd(tpr_pkg::ADDR_MODE, 8'h07, 8'hff);
    rd(tpr_pkg::ADDR_CFG, 8'h20, 8'hff);
    wr(tpr_pkg::ADDR_RES_HI, 8'hff);
    rd(tpr_pkg::ADDR_RES_HI, 8'h00, 8'hff);
    rd(8'h30, 8'h00, 8'hff);
    // every mode with both touch channels
    for (int m = 0; m < 8; m++) begin
      for (int c = 14; c < 16; c++) begin
        {pw, vr, up} = 7'($random(seed));
        wr(tpr_pkg::ADDR_MODE, {up, m[2:0]});
        wr(tpr_pkg::ADDR_CFG, {pw, 2'b01, vr, c[3:0]});
        rd(tpr_pkg::ADDR_MODE, {5'h00, m[2:0]}, 8'hff);
        rd(tpr_pkg::ADDR_CFG, {pw, 2'b01, vr, c[3:0]}, 8'hff);
        check({panel_x_plus, panel_x_minus, panel_y_plus, panel_y_minus}, pins_exp(m[2:0]));
        check({touch_controller_enable, touch_irq_enable}, {2{m != 7}});
        check({converter_enable, vref_enable, converter_channel}, {pw & (m != 7), vr, c[3:0]});
        check(touch_to_converter, (m != 7) && (c == 14 || m < 2));
      end
    end
    // conversions at full scale, zero and random values
    wr(tpr_pkg::ADDR_MODE, tpr_pkg::MODE_XPOS);
    wr(tpr_pkg::ADDR_CFG, 8'h80);
    convert(10'h3ff, 8'h14);
    convert(10'h000, 8'h00);
    for (int k = 0; k < 4; k++) convert(10'($random(seed)), k[0] ? 8'h14 : 8'h02);
    // start refused while the touch interface is disabled
    wr(tpr_pkg::ADDR_MODE, tpr_pkg::MODE_OFF);
    wr(tpr_pkg::ADDR_CFG, 8'hce);
    rd(tpr_pkg::ADDR_CFG, 8'hae, 8'hff);
    check(converter_enable, 1'b0);
    // power removed in mid-conversion, late answer ignored
    wr(tpr_pkg::ADDR_MODE, tpr_pkg::MODE_YPOS);
    sample = 10'h2aa;
    delay  = 8'h28;
    wr(tpr_pkg::ADDR_CFG, 8'hce);
    wr(tpr_pkg::ADDR_CFG, 8'h0e);
    rd(tpr_pkg::ADDR_CFG, 8'h0e, 8'hff);
    check(converter_enable, 1'b0);
    repeat (50) @(negedge clock);
    rd(tpr_pkg::ADDR_CFG, 8'h0e, 8'hff);
    rd(tpr_pkg::ADDR_RES_LO, res_prev[7:0], 8'hff);
    // mode 111 in mid-conversion aborts too, late answer ignored
    wr(tpr_pkg::ADDR_CFG, 8'h8e);
    wr(tpr_pkg::ADDR_CFG, 8'hce);
    wr(tpr_pkg::ADDR_MODE, tpr_pkg::MODE_OFF);
    rd(tpr_pkg::ADDR_CFG, 8'h8e, 8'hff);
    check(converter_enable, 1'b0);
    repeat (50) @(negedge clock);
    rd(tpr_pkg::ADDR_CFG, 8'h8e, 8'hff);
    rd(tpr_pkg::ADDR_RES_LO, res_prev[7:0], 8'hff);
    // let the monitor compare the last read before the verdict
    @(negedge clock);
    give_verdict();
  end
endmodule : test_tpr_touch_readout
